// File: verilog/wwd_pkg.sv
/*
 * Package for the window watchdog: register indices, field layout, reset
 * values and timing constants.
 * Assumes nothing of its surroundings.
 */
package wwd_pkg;
    // =====================================================================
    // Register map (printed offsets are indices; byte address = 4 * index)
    // =====================================================================
    localparam logic [7:0] WWD_IDX_CONTROL = 8'h00;
    localparam logic [7:0] WWD_IDX_WINDOW = 8'h01;
    localparam logic [7:0] WWD_IDX_MODE = 8'h02;
    localparam logic [7:0] WWD_IDX_STATUS = 8'h03;
    localparam int WWD_ADDR_LSB = 2;
    // =====================================================================
    // Fields and reset values
    // =====================================================================
    localparam int WWD_ACT_BIT = 7;
    localparam int WWD_TOP_BIT = 6;
    localparam logic [7:0] WWD_CONTROL_RST = 8'h7F;
    localparam logic [6:0] WWD_WINDOW_RST = 7'h7F;
    localparam logic [6:0] WWD_CNT_EXPIRE = 7'h3F;
    localparam logic [6:0] WWD_CNT_LAST = 7'h40;
    // Mode register bits
    localparam int WWD_MODE_HALT = 0;
    localparam int WWD_MODE_AHALT = 1;
    localparam int WWD_MODE_HALT_WAKE = 2;
    // =====================================================================
    // Timing
    // =====================================================================
    localparam int WWD_TICK_CYCLES = 12288;
    localparam int WWD_CLK_MHZ = 50;
    localparam int WWD_STAB_NS = 1000;
    localparam int WWD_STAB_CYCLES = (WWD_STAB_NS * WWD_CLK_MHZ + 999) / 1000;
    localparam logic [1:0] WWD_HTRANS_NONSEQ = 2'b10;
endpackage : wwd_pkg

// File: verilog/wwd_prescaler.sv
/*
 * Free-running prescaler for the window watchdog; one-cycle tick out.
 * Assumes a synchronous clock enable and the block's asynchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none
module wwd_prescaler #(
    parameter int DIV = 12288
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic run,
    output logic tick
);
    import wwd_pkg::*;

    localparam int CW = $clog2(DIV);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);
    logic [CW-1:0] cnt_r;

    // =====================================================================
    // Divider: never cleared by register writes, paused by run or clk_en low
    // =====================================================================
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_r <= '0;
        end else if (clk_en && run) begin
            cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
        end
    end

    // Tick on the last phase of each period
    assign tick = run && (cnt_r == LAST);
endmodule : wwd_prescaler
`default_nettype wire

// File: verilog/wwd_top.sv
/*
 * Window watchdog: 7-bit downcounter, window compare, reset request,
 * AHB-Lite register slave, low power mode handling.
 * Assumes a single AHB-Lite master, word accesses, and that the system
 * reset controller acts on mcu_reset_req and later asserts hresetn.
 */
// Implementation choice: the AHB-Lite slave port.
// Operation
// RQ1: Activated counter passing 0x40 to 0x3F requests MCU reset. Code: on a tick decrement only, not on the halt-entry decrement.
// RQ2: Reload while counter above window value requests MCU reset.
// RQ3: Software mode starts disabled; activate bit write-set, reset-cleared.
// RQ4: Hardware option keeps watchdog always active; activate bit unused.
// RQ5: Downcounter keeps decrementing even when not activated.
// RQ6: Decrement every 12288 clocks; prescaler phase kept over writes.
// RQ7: Control write with activate set and top bit clear resets at once.
// RQ8: Activated with halt option 1, halt request gives reset instead.
// RQ9: Halt option 0: one decrement, freeze, resume after stabilization delay.
// RQ10: Active-halt stops counter; resumes at once on interrupt.
// RQ11: Wait mode has no effect; counter keeps decrementing.
// RQ12: Window register holds 7-bit limit; both registers reset to 0x7F.
// RQ13: Control bit 7 activates, set-only; bits 6:0 read and load counter.
// RQ14: Software refreshes only below window, writing 0xC0 to 0xFF.
// RQ15: Window register bit 7 reads zero, writes ignored.
`timescale 1ns/1ps
`default_nettype none
module wwd_top #(
    parameter int TICK_CYCLES = wwd_pkg::WWD_TICK_CYCLES,
    parameter int STAB_CYCLES = wwd_pkg::WWD_STAB_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic hw_watchdog_opt,
    input wire logic halt_reset_option,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic mcu_reset_req
);
    import wwd_pkg::*;

    typedef enum logic [1:0] {
        WWD_RUN, WWD_HALT, WWD_AHALT, WWD_STAB
    } wwd_pm_t;

    logic act_r;
    logic [6:0] cnt_r;
    logic [6:0] win_r;
    logic rst_r;
    logic [31:0] rdata_r;
    logic wr_pend_r;
    logic [7:0] wr_idx_r;
    logic [2:0] mode_r;
    wwd_pm_t pm_r;
    logic [$clog2(STAB_CYCLES+1):0] stab_r;
    logic tick;
    logic run;
    logic active;
    logic ctl_wr;
    logic [7:0] wbyte;
    logic addr_ok;
    logic [7:0] a_idx;

    // Index decode from a byte address
    function automatic logic [7:0] wwd_idx(input logic [31:0] a);
        wwd_idx = a[WWD_ADDR_LSB +: 8];
    endfunction : wwd_idx

    // =====================================================================
    // Bus address phase
    // =====================================================================
    assign addr_ok = hsel && hready && (htrans == WWD_HTRANS_NONSEQ);
    assign a_idx = wwd_idx(haddr);
    assign wbyte = hwdata[7:0];
    assign ctl_wr = clk_en && wr_pend_r && (wr_idx_r == WWD_IDX_CONTROL);
    // Hardware option forces the watchdog active
    assign active = act_r || hw_watchdog_opt; // see RQ4

    // Latch write address phase for the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_idx_r <= 8'h00;
        end else if (clk_en) begin
            wr_pend_r <= addr_ok && hwrite;
            wr_idx_r <= a_idx;
        end
    end

    // Read data registered at the address phase; zero when unmapped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_r <= 32'h0000_0000;
        end else if (clk_en && addr_ok && !hwrite) begin
            case (a_idx)
                WWD_IDX_CONTROL: rdata_r <= {24'h0, act_r, cnt_r}; // see RQ13
                WWD_IDX_WINDOW: rdata_r <= {24'h0, 1'b0, win_r}; // see RQ15
                WWD_IDX_MODE: rdata_r <= {29'h0, mode_r};
                WWD_IDX_STATUS: rdata_r <= {30'h0, pm_r != WWD_RUN, rst_r};
                default: rdata_r <= 32'h0000_0000;
            endcase
        end
    end

    // Always ready, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end
    assign hrdata = rdata_r;

    // =====================================================================
    // Window and mode registers
    // =====================================================================
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            win_r <= WWD_WINDOW_RST; // see RQ12
        end else if (clk_en && wr_pend_r && wr_idx_r == WWD_IDX_WINDOW) begin
            win_r <= wbyte[6:0]; // see RQ15
        end
    end

    // Mode bits: halt, active-halt, wake are self-clearing requests
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_r <= 3'h0;
        end else if (clk_en) begin
            if (wr_pend_r && wr_idx_r == WWD_IDX_MODE) begin
                mode_r <= wbyte[2:0];
            end else begin
                mode_r <= 3'h0;
            end
        end
    end

    // =====================================================================
    // Low power state: halt, active-halt, stabilization
    // =====================================================================
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pm_r <= WWD_RUN;
            stab_r <= '0;
        end else if (clk_en) begin
            case (pm_r)
                WWD_RUN: begin
                    if (mode_r[WWD_MODE_HALT] &&
                        !(active && halt_reset_option)) begin
                        pm_r <= WWD_HALT; // see RQ9
                    end else if (mode_r[WWD_MODE_AHALT] &&
                                 !mode_r[WWD_MODE_HALT]) begin
                        // A halt request wins over a joint active-halt one
                        pm_r <= WWD_AHALT; // see RQ10
                    end
                end
                WWD_HALT: begin
                    if (mode_r[WWD_MODE_HALT_WAKE]) begin
                        pm_r <= WWD_STAB; // see RQ9
                        stab_r <= '0;
                    end
                end
                WWD_AHALT: begin
                    if (mode_r[WWD_MODE_HALT_WAKE]) begin
                        pm_r <= WWD_RUN; // see RQ10
                    end
                end
                WWD_STAB: begin
                    if (stab_r == ($bits(stab_r))'(STAB_CYCLES - 1)) begin
                        pm_r <= WWD_RUN;
                    end else begin
                        stab_r <= stab_r + 1'b1;
                    end
                end
                default: pm_r <= WWD_RUN;
            endcase
        end
    end

    // Counting runs in run mode; wait mode is not visible here
    assign run = (pm_r == WWD_RUN); // see RQ11

    // =====================================================================
    // Prescaler and downcounter
    // =====================================================================
    wwd_prescaler #(
        .DIV(TICK_CYCLES)
    ) u_pre (
        .hclk(hclk),
        .hresetn(hresetn),
        .clk_en(clk_en),
        .run(run),
        .tick(tick)
    ); // see RQ6

    // Counter: loaded by control writes, otherwise decremented by one on a tick or on a halt request that enters halt
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_r <= WWD_CONTROL_RST[6:0]; // see RQ12
        end else if (clk_en) begin
            if (ctl_wr) begin
                cnt_r <= wbyte[6:0]; // see RQ13
            end else if (tick || (pm_r == WWD_RUN && mode_r[WWD_MODE_HALT]
                         && !(active && halt_reset_option))) begin
                cnt_r <= cnt_r - 7'h01; // see RQ5
            end
        end
    end

    // Activate bit: set-only, cleared by reset alone
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            act_r <= WWD_CONTROL_RST[WWD_ACT_BIT]; // see RQ3
        end else if (clk_en && ctl_wr && wbyte[WWD_ACT_BIT]) begin
            act_r <= 1'b1; // see RQ3
        end
    end

    // =====================================================================
    // Reset request, sticky until the system reset lands
    // =====================================================================
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rst_r <= 1'b0;
        end else if (clk_en) begin
            if (active && tick && !ctl_wr && cnt_r == WWD_CNT_LAST) begin
                rst_r <= 1'b1; // see RQ1
            end
            if (ctl_wr && active && cnt_r > win_r) begin
                rst_r <= 1'b1; // see RQ2
            end
            if (ctl_wr && (active || wbyte[WWD_ACT_BIT]) &&
                !wbyte[WWD_TOP_BIT]) begin
                rst_r <= 1'b1; // see RQ7
            end
            if (pm_r == WWD_RUN && mode_r[WWD_MODE_HALT] && active &&
                halt_reset_option) begin
                rst_r <= 1'b1; // see RQ8
            end
        end
    end
    assign mcu_reset_req = rst_r;

    // =====================================================================
    // Checks
    // =====================================================================
    sequence s_expire;
        active && tick && !ctl_wr && cnt_r == WWD_CNT_LAST && clk_en;
    endsequence
    property p_expire;
        @(posedge hclk) disable iff (!hresetn)
        s_expire |=> mcu_reset_req && cnt_r == WWD_CNT_EXPIRE;
    endproperty
    a_expire: assert property (p_expire) // see RQ1
        else $error("no expiry reset");
    property p_window;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && ctl_wr && active && cnt_r > win_r) |=> mcu_reset_req;
    endproperty
    a_window: assert property (p_window) // see RQ2
        else $error("early reload");
    property p_act_sticky;
        @(posedge hclk) disable iff (!hresetn)
        $fell(act_r) |-> 1'b0;
    endproperty
    a_act_sticky: assert property (p_act_sticky) // see RQ3
        else $error("act cleared");
    property p_hw_only;
        @(posedge hclk) disable iff (!hresetn)
        (hw_watchdog_opt && tick && clk_en && !ctl_wr
         && cnt_r == WWD_CNT_LAST) |=> mcu_reset_req;
    endproperty
    a_hw_only: assert property (p_hw_only) // see RQ4
        else $error("hw mode idle");
    property p_dec;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && tick && !ctl_wr) |=> cnt_r == $past(cnt_r) - 7'h01;
    endproperty
    a_dec: assert property (p_dec) // see RQ5
        else $error("no decrement");
    property p_swrst;
        @(posedge hclk) disable iff (!hresetn)
        (ctl_wr && wbyte[WWD_ACT_BIT] && !wbyte[WWD_TOP_BIT])
        |=> mcu_reset_req;
    endproperty
    a_swrst: assert property (p_swrst) // see RQ7
        else $error("no soft reset");
    property p_halt_rst;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && run && mode_r[WWD_MODE_HALT] && active &&
         halt_reset_option) |=> mcu_reset_req && pm_r == WWD_RUN;
    endproperty
    a_halt_rst: assert property (p_halt_rst) // see RQ8
        else $error("halt no reset");
    property p_frozen;
        @(posedge hclk) disable iff (!hresetn)
        (pm_r != WWD_RUN && !ctl_wr) |=> $stable(cnt_r);
    endproperty
    a_frozen: assert property (p_frozen) // see RQ10
        else $error("counts in halt");
    // Window read returns the stored limit with the reserved bit at zero
    property p_win_res;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && addr_ok && !hwrite && a_idx == WWD_IDX_WINDOW)
        |=> hrdata[7:0] == {1'b0, $past(win_r)};
    endproperty
    a_win_res: assert property (p_win_res) // see RQ15
        else $error("window read");
endmodule : wwd_top
`default_nettype wire

// File: sim/tb.sv
/*
 * Self-checking bench for the window watchdog top over AHB-Lite.
 * Assumes wwd_top with a short tick (16) and stabilization count (4).
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import wwd_pkg::*;
    localparam int TICK = 16;
    localparam int STAB = 4;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic clk_en = 1'b1;
    logic hw_opt = 1'b0;
    logic halt_opt = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic mcu_reset_req;
    logic rd_dp = 1'b0;
    logic exp_rst = 1'b0;
    logic [31:0] last_rd = 32'h0;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    logic [31:0] rnd = 32'h1522;
    int n_fail = 0;
    int n_compared = 0;
    // =====================================================================
    // Clock and design
    // =====================================================================
    always #10 hclk = ~hclk;
    wwd_top #(.TICK_CYCLES(TICK), .STAB_CYCLES(STAB)) i_dut (
        .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
        .hw_watchdog_opt(hw_opt), .halt_reset_option(halt_opt),
        .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .mcu_reset_req(mcu_reset_req)
    );
    // =====================================================================
    // Helpers
    // =====================================================================
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    task automatic print_verdict;
        $display("Compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
            n_fail++;
        end
    endtask : check
    // Bounded wait for hready at a rising edge
    task automatic wait_ready;
        int i;
        i = 0;
        do begin
            @(posedge hclk);
            i++;
        end while (hreadyout !== 1'b1 && i < 50);
        if (hreadyout !== 1'b1) begin
            n_fail++;
            print_verdict();
        end
    endtask : wait_ready
    // One single word transfer; reads note their expectation
    task automatic xfer(input logic wr, input logic [7:0] idx,
                        input logic [7:0] d, input logic [7:0] e,
                        input logic [7:0] m);
        @(posedge hclk);
        haddr <= {22'h0, idx, 2'h0};
        htrans <= WWD_HTRANS_NONSEQ;
        hwrite <= wr;
        if (!wr) begin
            exp_q.push_back({exp_rst, 23'h0, e});
            msk_q.push_back({1'b1, 23'h7FFFFF, m});
        end
        wait_ready();
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        rd_dp <= !wr;
        wait_ready();
        rd_dp <= 1'b0;
    endtask : xfer
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        xfer(1'b1, idx, d, 8'h00, 8'h00);
    endtask : wr
    task automatic rd(input logic [7:0] idx, input logic [7:0] e,
                      input logic [7:0] m);
        xfer(1'b0, idx, 8'h00, e, m);
    endtask : rd
    // Bench plays the reset controller; options change under reset
    task automatic do_reset(input logic hw, input logic ho);
        @(posedge hclk);
        hresetn <= 1'b0;
        hw_opt <= hw;
        halt_opt <= ho;
        exp_rst = 1'b0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
    endtask : do_reset
    // Monitor: reset request folded into bit 31, error response into bit 30
    always @(posedge hclk) begin
        if (rd_dp === 1'b1 && hreadyout === 1'b1) begin
            check({mcu_reset_req, hrdata[30] | hresp, hrdata[29:0]}
                  & msk_q.pop_front(), exp_q.pop_front());
            last_rd <= hrdata;
        end
    end
    // =====================================================================
    // Scenarios
    // =====================================================================
    initial begin
        int k;
        logic [7:0] w;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        rd(WWD_IDX_CONTROL, 8'h7F, 8'hFF);
        rd(WWD_IDX_WINDOW, 8'h7F, 8'hFF);
        // Random window values, reserved bit, unmapped places
        for (k = 0; k < 4; k++) begin
            rnd = xs(rnd);
            w = rnd[7:0] | 8'h80;
            wr(WWD_IDX_WINDOW, w);
            rd(WWD_IDX_WINDOW, w & 8'h7F, 8'hFF);
            wr({6'h01, rnd[9:8]}, rnd[15:8]);
            rd({6'h01, rnd[9:8]}, 8'h00, 8'hFF);
        end
        // Counter load, then exact decrement spacing while inactive
        wr(WWD_IDX_CONTROL, 8'h55);
        rd(WWD_IDX_CONTROL, 8'h55, 8'hFF);
        repeat (3 * TICK - 3) @(posedge hclk);
        rd(WWD_IDX_CONTROL, 8'h52, 8'hFF);
        // Software triggered reset
        wr(WWD_IDX_CONTROL, 8'hBF);
        exp_rst = 1'b1;
        rd(WWD_IDX_STATUS, 8'h01, 8'h01);
        do_reset(1'b0, 1'b0);
        rd(WWD_IDX_CONTROL, 8'h00, 8'h80);
        // Activate bit is set-only; reload above window resets
        wr(WWD_IDX_CONTROL, 8'hFF);
        wr(WWD_IDX_CONTROL, 8'h7F);
        rd(WWD_IDX_CONTROL, 8'h80, 8'h80);
        wr(WWD_IDX_WINDOW, 8'h50);
        wr(WWD_IDX_CONTROL, 8'hFF);
        exp_rst = 1'b1;
        rd(WWD_IDX_STATUS, 8'h01, 8'h01);
        // Refresh inside window keeps alive; expiry at 0x3F resets
        do_reset(1'b0, 1'b0);
        wr(WWD_IDX_CONTROL, 8'hC4);
        repeat (3 * TICK) @(posedge hclk);
        wr(WWD_IDX_CONTROL, 8'hC4);
        rd(WWD_IDX_STATUS, 8'h00, 8'h01);
        repeat (3 * TICK) @(posedge hclk);
        rd(WWD_IDX_STATUS, 8'h00, 8'h01);
        repeat (3 * TICK) @(posedge hclk);
        exp_rst = 1'b1;
        rd(WWD_IDX_STATUS, 8'h01, 8'h01);
        // Hardware option forces activation; software mode does not
        for (k = 0; k < 2; k++) begin
            do_reset(k[0], 1'b0);
            wr(WWD_IDX_CONTROL, 8'h42);
            repeat (4 * TICK) @(posedge hclk);
            exp_rst = k[0];
            rd(WWD_IDX_STATUS, {7'h00, k[0]}, 8'h01);
        end
        // Halt with reset option
        do_reset(1'b0, 1'b1);
        wr(WWD_IDX_CONTROL, 8'hFF);
        wr(WWD_IDX_MODE, 8'h01);
        exp_rst = 1'b1;
        rd(WWD_IDX_STATUS, 8'h01, 8'h03);
        // Halt and active-halt freeze near expiry, then wake
        for (k = 0; k < 2; k++) begin
            do_reset(1'b0, 1'b0);
            wr(WWD_IDX_CONTROL, 8'hC2);
            wr(WWD_IDX_MODE, k[0] ? 8'h02 : 8'h01);
            rd(WWD_IDX_STATUS, 8'h02, 8'h03);
            rd(WWD_IDX_CONTROL, 8'h00, 8'h00);
            repeat (5 * TICK) @(posedge hclk);
            rd(WWD_IDX_CONTROL, last_rd[7:0], 8'hFF);
            rd(WWD_IDX_STATUS, 8'h02, 8'h03);
            wr(WWD_IDX_MODE, 8'h04);
            rd(WWD_IDX_STATUS, k[0] ? 8'h00 : 8'h02, 8'h02);
            // Back in run once the stabilization count has passed
            repeat (STAB) @(posedge hclk);
            rd(WWD_IDX_STATUS, 8'h00, 8'h02);
        end
        // Clock enable low freezes the register side: the write is lost
        clk_en <= 1'b0;
        wr(WWD_IDX_WINDOW, 8'h11);
        repeat (3 * TICK) @(posedge hclk);
        clk_en <= 1'b1;
        rd(WWD_IDX_WINDOW, 8'h7F, 8'hFF);
        print_verdict();
    end
endmodule : tb
`default_nettype wire
